/* design/avm_defines.vh */
`ifndef AVM_DEFINES_VH
`define AVM_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AVM_ADDR_THS_HIGH   8'h60
`define AVM_ADDR_THS_LOW    8'h61
`define AVM_ADDR_DB_COUNT   8'h62
`define AVM_ADDR_REFX_HIGH  8'h63
`define AVM_ADDR_REFX_LOW   8'h64
`define AVM_ADDR_REFY_HIGH  8'h65
`define AVM_ADDR_REFY_LOW   8'h66
`define AVM_ADDR_REFZ_HIGH  8'h67
`define AVM_ADDR_REFZ_LOW   8'h68

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define AVM_DBMODE_BIT      7
`define AVM_THS_HI_MSB      4
`define AVM_REF_HI_MSB      5
`define AVM_THS_W           13
`define AVM_DATA_W          14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AVM_RST_BYTE        8'h00
`define AVM_RST_REF         14'h0000

`endif

/* design/avm_sqdist_cmp.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Squared distance against squared threshold
// ----------------------------------------
module avm_sqdist_cmp #(
  parameter DW = 14,
  parameter TW = 13
) (
  // Current sample
  input  wire signed [DW-1:0] cur_x,
  input  wire signed [DW-1:0] cur_y,
  input  wire signed [DW-1:0] cur_z,
  // Reference vector
  input  wire signed [DW-1:0] ref_x,
  input  wire signed [DW-1:0] ref_y,
  input  wire signed [DW-1:0] ref_z,
  // Threshold and result
  input  wire        [TW-1:0] thresh,
  output wire                 above
);

  wire signed [DW:0]      dx;
  wire signed [DW:0]      dy;
  wire signed [DW:0]      dz;
  wire        [2*DW+1:0]  sx;
  wire        [2*DW+1:0]  sy;
  wire        [2*DW+1:0]  sz;
  wire        [2*DW+3:0]  sum;
  wire        [2*DW+3:0]  tsq;
  wire        [2*TW-1:0]  tprod;

  // One extra bit so full-scale differences cannot wrap
  assign dx  = {cur_x[DW-1], cur_x} - {ref_x[DW-1], ref_x};
  assign dy  = {cur_y[DW-1], cur_y} - {ref_y[DW-1], ref_y};
  assign dz  = {cur_z[DW-1], cur_z} - {ref_z[DW-1], ref_z};
  assign sx  = dx * dx;
  assign sy  = dy * dy;
  assign sz  = dz * dz;
  assign sum = {2'b00, sx} + {2'b00, sy} + {2'b00, sz};
  // Square in its own full-width net; inside a concatenation it would be cut to TW bits
  assign tprod = thresh * thresh;
  assign tsq   = {{(2*DW+4-2*TW){1'b0}}, tprod};
  // Both sides non-negative integers, so no square root is needed
  assign above = (sum > tsq);

endmodule

`default_nettype wire

/* design/avm_detector.v */
`timescale 1ns/1ps
`default_nettype none

`include "avm_defines.vh"

// Operation
// - Flag event when vector distance exceeds threshold beyond debounce count.
// - Latch off: flag follows condition; latch on: hold until source read.
// - On enable, reference from live data or from initial registers.
// - After trigger, update reference from live data unless update mode set.
// - Debounce mode 0: counter decrements on below-threshold sample.
// - Debounce mode 1: counter clears on below-threshold sample.
// - 13-bit threshold, bits 12:8 in high register beside mode bit 7.
// - Threshold bits 7:0 in low register; LSB matches acceleration data.
// - 8-bit debounce count, period is count times one step: one sample period, or two in hybrid mode.
// - Hybrid mode steps the debounce counter at half the sample rate.
// - Initial references are signed 14-bit, split into high and low registers.
// - Initial registers load the reference on enable while select bit is one, and every cycle while update mode is also set.
// - Initial references share the acceleration output LSB weight.
module avm_detector #(
  parameter DW = `AVM_DATA_W,
  parameter TW = `AVM_THS_W
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 sys_rst,
  // Register port
  input  wire        [7:0]    reg_addr,
  input  wire        [7:0]    reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg         [7:0]    reg_rdata,
  // Configuration bits
  input  wire                 vm_enable,
  input  wire                 vm_latch_en,
  input  wire                 vm_init_sel,
  input  wire                 vm_update_mode,
  input  wire                 hybrid_mode,
  // Sample stream
  input  wire                 sample_tick,
  input  wire signed [DW-1:0] accel_x,
  input  wire signed [DW-1:0] accel_y,
  input  wire signed [DW-1:0] accel_z,
  // Event
  input  wire                 int_source_read,
  output reg                  vm_event
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        [7:0]    ths_high_reg;
  reg        [7:0]    ths_low_reg;
  reg        [7:0]    db_count_reg;
  reg        [DW-1:0] init_x_reg;
  reg        [DW-1:0] init_y_reg;
  reg        [DW-1:0] init_z_reg;
  reg        [DW-1:0] ref_x_reg;
  reg        [DW-1:0] ref_y_reg;
  reg        [DW-1:0] ref_z_reg;
  reg        [7:0]    dbc_reg;
  reg        [7:0]    dbc_next;
  reg                 en_d_reg;
  reg                 half_reg;
  reg                 trig_reg;
  reg        [7:0]    rdata_next;

  wire       [TW-1:0] thresh;
  wire                above;
  wire                step;
  wire                trig_next;
  wire                en_rise;

  assign thresh = {ths_high_reg[`AVM_THS_HI_MSB:0], ths_low_reg};
  assign en_rise = vm_enable & ~en_d_reg;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ths_high_reg <= `AVM_RST_BYTE;
      ths_low_reg  <= `AVM_RST_BYTE;
      db_count_reg <= `AVM_RST_BYTE;
      init_x_reg   <= `AVM_RST_REF;
      init_y_reg   <= `AVM_RST_REF;
      init_z_reg   <= `AVM_RST_REF;
    end else if (reg_wr) begin
      case (reg_addr)
        `AVM_ADDR_THS_HIGH:  ths_high_reg <= reg_wdata & 8'h9f;
        `AVM_ADDR_THS_LOW:   ths_low_reg  <= reg_wdata;
        `AVM_ADDR_DB_COUNT:  db_count_reg <= reg_wdata;
        `AVM_ADDR_REFX_HIGH: init_x_reg[DW-1:8] <= reg_wdata[`AVM_REF_HI_MSB:0];
        `AVM_ADDR_REFX_LOW:  init_x_reg[7:0]    <= reg_wdata;
        `AVM_ADDR_REFY_HIGH: init_y_reg[DW-1:8] <= reg_wdata[`AVM_REF_HI_MSB:0];
        `AVM_ADDR_REFY_LOW:  init_y_reg[7:0]    <= reg_wdata;
        `AVM_ADDR_REFZ_HIGH: init_z_reg[DW-1:8] <= reg_wdata[`AVM_REF_HI_MSB:0];
        `AVM_ADDR_REFZ_LOW:  init_z_reg[7:0]    <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    case (reg_addr)
      `AVM_ADDR_THS_HIGH:  rdata_next = ths_high_reg;
      `AVM_ADDR_THS_LOW:   rdata_next = ths_low_reg;
      `AVM_ADDR_DB_COUNT:  rdata_next = db_count_reg;
      `AVM_ADDR_REFX_HIGH: rdata_next = {2'b00, init_x_reg[DW-1:8]};
      `AVM_ADDR_REFX_LOW:  rdata_next = init_x_reg[7:0];
      `AVM_ADDR_REFY_HIGH: rdata_next = {2'b00, init_y_reg[DW-1:8]};
      `AVM_ADDR_REFY_LOW:  rdata_next = init_y_reg[7:0];
      `AVM_ADDR_REFZ_HIGH: rdata_next = {2'b00, init_z_reg[DW-1:8]};
      `AVM_ADDR_REFZ_LOW:  rdata_next = init_z_reg[7:0];
      default:             rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // Magnitude compare
  // ----------------------------------------
  // Reference LSB equals data LSB, so raw values subtract directly
  avm_sqdist_cmp #(
    .DW (DW),
    .TW (TW)
  ) u_cmp (
    .cur_x  (accel_x),
    .cur_y  (accel_y),
    .cur_z  (accel_z),
    .ref_x  (ref_x_reg),
    .ref_y  (ref_y_reg),
    .ref_z  (ref_z_reg),
    .thresh (thresh),
    .above  (above)
  );

  // ----------------------------------------
  // Sample step and debounce
  // ----------------------------------------
  // Hybrid mode uses every other sample tick
  assign step = sample_tick & vm_enable & (~hybrid_mode | half_reg);

  always @* begin
    dbc_next = dbc_reg;
    if (step) begin
      if (above) begin
        if (dbc_reg < db_count_reg) begin
          dbc_next = dbc_reg + 8'h01;
        end
      end else if (ths_high_reg[`AVM_DBMODE_BIT]) begin
        dbc_next = 8'h00;
      end else if (dbc_reg != 8'h00) begin
        dbc_next = dbc_reg - 8'h01;
      end
    end
  end

  // Counter must be at the full count and the condition true on the latest step
  assign trig_next = vm_enable & (dbc_next == db_count_reg) & (step ? above : trig_reg);

  always @(posedge clk) begin
    if (sys_rst) begin
      dbc_reg  <= 8'h00;
      half_reg <= 1'b0;
      en_d_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      en_d_reg <= vm_enable;
      trig_reg <= trig_next;
      if (!vm_enable) begin
        dbc_reg  <= 8'h00;
        half_reg <= 1'b0;
      end else begin
        dbc_reg <= dbc_next;
        if (sample_tick) begin
          half_reg <= ~half_reg;
        end
      end
    end
  end

  // ----------------------------------------
  // Reference vector
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ref_x_reg <= `AVM_RST_REF;
      ref_y_reg <= `AVM_RST_REF;
      ref_z_reg <= `AVM_RST_REF;
    end else if (en_rise | (vm_init_sel & vm_update_mode)) begin
      // Held registers also let software steer the reference live
      ref_x_reg <= vm_init_sel ? init_x_reg : accel_x;
      ref_y_reg <= vm_init_sel ? init_y_reg : accel_y;
      ref_z_reg <= vm_init_sel ? init_z_reg : accel_z;
    end else if (trig_next & ~trig_reg & ~vm_update_mode) begin
      ref_x_reg <= accel_x;
      ref_y_reg <= accel_y;
      ref_z_reg <= accel_z;
    end
  end

  // ----------------------------------------
  // Event flag
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      vm_event <= 1'b0;
    end else if (vm_latch_en) begin
      // New trigger wins over a coinciding source read
      if (trig_next & ~trig_reg) begin
        vm_event <= 1'b1;
      end else if (int_source_read) begin
        vm_event <= 1'b0;
      end
    end else begin
      vm_event <= trig_next;
    end
  end

endmodule

`default_nettype wire

/* test/avm_detector_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module avm_detector_chk (
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  // Configuration
  input wire logic               vm_enable,
  input wire logic               vm_latch_en,
  input wire logic               vm_init_sel,
  input wire logic               vm_update_mode,
  input wire logic               hybrid_mode,
  // Samples and event
  input wire logic               sample_tick,
  input wire logic signed [13:0] accel_x,
  input wire logic signed [13:0] accel_y,
  input wire logic signed [13:0] accel_z,
  input wire logic               int_source_read,
  input wire logic               vm_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_hold_a: assert property ($past(!reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmap_zero_a: assert property (reg_rd && (reg_addr < 8'h60 || reg_addr > 8'h68)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  ths_rsvd_a: assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata[6:5] == 2'h0)
    else $error("threshold high spare bits set");
  ref_rsvd_a: assert property (reg_rd && reg_addr inside {8'h63, 8'h65, 8'h67}
    |=> reg_rdata[7:6] == 2'h0) else $error("reference high spare bits set");
  cnt_rw_a: assert property (reg_wr && reg_addr == 8'h62 ##2 reg_rd && reg_addr == 8'h62
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("count readback wrong");
  ev_rise_a: assert property ($rose(vm_event) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("event rose without a sample");
  latch_hold_a: assert property (vm_latch_en && vm_event && !int_source_read
    |=> vm_event) else $error("latched event dropped");
  // Two quiet cycles so a pipelined flag update is not mistaken for a glitch
  live_hold_a: assert property (!vm_latch_en && vm_enable && $past(vm_enable) && !sample_tick
    && $past(!sample_tick) |=> $stable(vm_event)) else $error("live event moved between samples");
  latch_fall_a: assert property ($fell(vm_event) && $past(vm_latch_en)
    |-> $past(int_source_read) || $past(int_source_read, 2)) else $error("latched event cleared early");
endmodule

bind avm_detector avm_detector_chk chk_u (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vm_enable(vm_enable),
  .vm_latch_en(vm_latch_en), .vm_init_sel(vm_init_sel), .vm_update_mode(vm_update_mode),
  .hybrid_mode(hybrid_mode), .sample_tick(sample_tick), .accel_x(accel_x),
  .accel_y(accel_y), .accel_z(accel_z), .int_source_read(int_source_read), .vm_event(vm_event));
`default_nettype wire

/* test/avm_detector_test.sv */
`timescale 1ns/1ps
`default_nettype none
module avm_detector_test;
  logic              clk = 1'h0;
  logic              sys_rst = 1'h1;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'h0;
  logic              reg_rd = 1'h0;
  logic              vm_enable = 1'h0;
  logic              vm_latch_en = 1'h0;
  logic              vm_init_sel = 1'h0;
  logic              vm_update_mode = 1'h1;
  logic              hybrid_mode = 1'h0;
  logic              sample_tick = 1'h0;
  logic              int_source_read = 1'h0;
  logic signed [13:0] accel_x = 14'h0;
  logic signed [13:0] accel_y = 14'h0;
  logic signed [13:0] accel_z = 14'h0;
  wire [7:0]         reg_rdata;
  wire               vm_event;
  int                fail_count = 0;
  int                n_checks = 0;

  always #50 clk = ~clk;

  avm_detector dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vm_enable(vm_enable),
    .vm_latch_en(vm_latch_en), .vm_init_sel(vm_init_sel), .vm_update_mode(vm_update_mode),
    .hybrid_mode(hybrid_mode), .sample_tick(sample_tick), .accel_x(accel_x),
    .accel_y(accel_y), .accel_z(accel_z), .int_source_read(int_source_read), .vm_event(vm_event));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  // Accel stays put after the tick, since enable samples it for the reference
  task automatic tk(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z, input logic e);
    @(posedge clk);
    sample_tick <= 1'h1;
    accel_x <= x;
    accel_y <= y;
    accel_z <= z;
    @(posedge clk);
    sample_tick <= 1'h0;
    @(posedge clk);
    #1 chk(vm_event, e);
  endtask
  task automatic cfg(input logic en, input logic l, input logic i, input logic u, input logic h);
    @(posedge clk);
    vm_enable <= en;
    vm_latch_en <= l;
    vm_init_sel <= i;
    vm_update_mode <= u;
    hybrid_mode <= h;
    @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 9; i++) begin
      rd(8'h60 + i[7:0], 8'h00);
      wr(8'h60 + i[7:0], 8'hff);
      rd(8'h60 + i[7:0], i == 0 ? 8'h9f : (i > 2 && i[0]) ? 8'h3f : 8'hff);
    end
    wr(8'h69, 8'hff);
    rd(8'h69, 8'h00);
    $display("test registers done");
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h0a);
    wr(8'h62, 8'h02);
    wr(8'h63, 8'h3f);
    wr(8'h64, 8'h9c);
    for (int a = 8'h65; a < 8'h69; a++)
      wr(a[7:0], 8'h00);
    cfg(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    tk(14'h6, 14'h8, 14'h0, 1'h0);
    tk(14'h6, 14'h8, 14'h1, 1'h0);
    tk(14'h6, 14'h8, 14'h1, 1'h1);
    tk(14'h0, 14'h0, 14'h0, 1'h0);
    tk(14'h6, 14'h8, 14'h1, 1'h1);
    $display("test decrement done");
    wr(8'h60, 8'h80);
    tk(14'h0, 14'h0, 14'h0, 1'h0);
    tk(14'h6, 14'h8, 14'h1, 1'h0);
    tk(14'h6, 14'h8, 14'h1, 1'h1);
    $display("test clear mode done");
    // Disable first: a live count change would move the flag between samples
    cfg(1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    wr(8'h60, 8'h00);
    wr(8'h62, 8'h00);
    cfg(1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    tk(14'h3f9c, 14'h0, 14'h0, 1'h0);
    tk(14'h3fa7, 14'h0, 14'h0, 1'h1);
    tk(14'h3fa6, 14'h0, 14'h0, 1'h0);
    $display("test init reference done");
    cfg(1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    tk(14'h3fa7, 14'h0, 14'h0, 1'h1);
    tk(14'h3f9c, 14'h0, 14'h0, 1'h1);
    @(posedge clk);
    int_source_read <= 1'h1;
    @(posedge clk);
    int_source_read <= 1'h0;
    @(posedge clk);
    #1 chk(vm_event, 1'h0);
    $display("test latch done");
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    cfg(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    tk(14'h3fb0, 14'h0, 14'h0, 1'h1);
    tk(14'h3fb0, 14'h0, 14'h0, 1'h0);
    $display("test update done");
    wr(8'h62, 8'h01);
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    cfg(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    tk(14'h0, 14'h0, 14'h0, 1'h0);
    tk(14'h0, 14'h0, 14'h0, 1'h1);
    $display("test hybrid done");
    tally_and_finish();
  end

  // Whole run is under 200 cycles; this is over ten times that
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
